/* secc_ctrl.sv */
// Serial ROM command controller with AHB-Lite register slave
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "secc_params.svh"

module secc_ctrl import secc_pkg::*; #(
  parameter int TIMEOUT_CYC = `SECC_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // Serial ROM engine
  output logic ROM_REQ,
  output logic [2:0] ROM_OP,
  output logic [7:0] ROM_ADDR,
  output logic [7:0] ROM_WDATA,
  input wire logic ROM_DONE,
  input wire logic [7:0] ROM_RDATA,
  // Status
  output logic [47:0] HW_ADDR,
  output logic IRQ
);
  localparam secc_op_t OP_READ = 3'h0;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  secc_tmo_if tmo ();

  secc_timer #(.LIMIT(TIMEOUT_CYC)) u_timer (
    .clk(CLK),
    .rst(RST),
    .tmo(tmo)
  );

  // Bus address phase capture
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ap_valid;

  // Controller state
  secc_state_t state_r;
  secc_state_t state_nxt;
  logic busy_r;
  logic busy_nxt;
  secc_op_t op_r;
  secc_op_t op_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic [2:0] boot_idx_r;
  logic [2:0] boot_idx_nxt;
  logic [47:0] hwaddr_r;
  logic [47:0] hwaddr_nxt;
  logic req_r;
  logic req_nxt;
  logic [1:0] istat_r;
  logic [1:0] istat_nxt;
  logic [1:0] ien_r;
  logic [1:0] ien_nxt;
  logic [1:0] ev;
  logic [1:0] clr;

  assign ap_valid = HSEL && HREADY && HTRANS[1];

  always_comb begin
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt = rdata_r;
    if (ap_valid) begin
      wr_pend_nxt = HWRITE;
      wr_addr_nxt = HADDR[7:0];
      rdata_nxt = 32'h0000_0000;
      if (!HWRITE) begin
        if (reg_hit(HADDR[7:0], `SECC_CMD_OFS)) begin
          rdata_nxt[`SECC_BUSY_BIT] = busy_r;
          rdata_nxt[`SECC_OP_HI:`SECC_OP_LO] = op_r;
          rdata_nxt[`SECC_ADDR_HI:`SECC_ADDR_LO] = addr_r;
        end else if (reg_hit(HADDR[7:0], `SECC_DATA_OFS)) begin
          rdata_nxt[`SECC_DATA_HI:`SECC_DATA_LO] = data_r;
        end else if (reg_hit(HADDR[7:0], `SECC_ISTAT_OFS)) begin
          rdata_nxt[1:0] = istat_r;
        end else if (reg_hit(HADDR[7:0], `SECC_IEN_OFS)) begin
          rdata_nxt[1:0] = ien_r;
        end
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    busy_nxt = busy_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    boot_idx_nxt = boot_idx_r;
    hwaddr_nxt = hwaddr_r;
    req_nxt = 1'b0;
    ev = 2'b00;
    clr = 2'b00;
    tmo.start = 1'b0;
    tmo.run = 1'b0;
    case (state_r)
      BOOT_REQ: begin
        req_nxt = 1'b1;
        tmo.start = 1'b1;
        tmo.run = 1'b1;
        op_nxt = OP_READ;
        addr_nxt = `SECC_BOOT_BASE + 8'(boot_idx_r);
        state_nxt = BOOT_WAIT;
      end
      BOOT_WAIT: begin
        tmo.run = 1'b1;
        if (ROM_DONE) begin
          hwaddr_nxt[boot_idx_r * 8 +: 8] = ROM_RDATA;
          if (boot_idx_r == `SECC_BOOT_LAST) begin
            busy_nxt = 1'b0;
            op_nxt = `SECC_OP_RST;
            addr_nxt = `SECC_ADDR_RST;
            state_nxt = IDLE;
          end else begin
            boot_idx_nxt = boot_idx_r + 3'h1;
            state_nxt = BOOT_REQ;
          end
        end else if (tmo.expired) begin
          // Missing device: give up the load and leave the address cleared
          busy_nxt = 1'b0;
          op_nxt = `SECC_OP_RST;
          addr_nxt = `SECC_ADDR_RST;
          state_nxt = IDLE;
        end
      end
      IDLE: begin
        // Command and data writes during busy are ignored, protecting the command in flight
        if (wr_pend_r && reg_hit(wr_addr_r, `SECC_CMD_OFS)) begin
          op_nxt = HWDATA[`SECC_OP_HI:`SECC_OP_LO];
          addr_nxt = HWDATA[`SECC_ADDR_HI:`SECC_ADDR_LO];
          if (HWDATA[`SECC_BUSY_BIT]) begin
            busy_nxt = 1'b1;
            req_nxt = 1'b1;
            tmo.start = 1'b1;
            state_nxt = RUN;
          end
        end
        if (wr_pend_r && reg_hit(wr_addr_r, `SECC_DATA_OFS)) begin
          data_nxt = HWDATA[`SECC_DATA_HI:`SECC_DATA_LO];
        end
      end
      RUN: begin
        tmo.run = 1'b1;
        if (ROM_DONE) begin
          if (op_r == OP_READ) begin
            data_nxt = ROM_RDATA;
          end
          busy_nxt = 1'b0;
          ev[`SECC_IRQ_DONE_BIT] = 1'b1;
          state_nxt = IDLE;
        end else if (tmo.expired) begin
          busy_nxt = 1'b0;
          ev[`SECC_IRQ_TMO_BIT] = 1'b1;
          state_nxt = IDLE;
        end
      end
      default: begin
        state_nxt = IDLE;
        busy_nxt = 1'b0;
      end
    endcase
    ien_nxt = ien_r;
    if (wr_pend_r && reg_hit(wr_addr_r, `SECC_IEN_OFS)) begin
      ien_nxt = HWDATA[1:0];
    end
    if (wr_pend_r && reg_hit(wr_addr_r, `SECC_ICLR_OFS)) begin
      clr = HWDATA[1:0];
    end
    // A new event in the clearing cycle survives
    istat_nxt = (istat_r & ~clr) | ev;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
      state_r <= BOOT_REQ;
      busy_r <= 1'b1;
      op_r <= `SECC_OP_RST;
      addr_r <= `SECC_ADDR_RST;
      data_r <= `SECC_DATA_RST;
      boot_idx_r <= 3'h0;
      hwaddr_r <= `SECC_HWADDR_RST;
      req_r <= 1'b0;
      istat_r <= `SECC_IRQ_RST;
      ien_r <= `SECC_IRQ_RST;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      busy_r <= busy_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      boot_idx_r <= boot_idx_nxt;
      hwaddr_r <= hwaddr_nxt;
      req_r <= req_nxt;
      istat_r <= istat_nxt;
      ien_r <= ien_nxt;
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_r;
  assign ROM_REQ = req_r;
  assign ROM_OP = op_r;
  assign ROM_ADDR = addr_r;
  assign ROM_WDATA = data_r;
  assign HW_ADDR = hwaddr_r;
  assign IRQ = |(istat_r & ien_r);
endmodule

/* secc_ctrl_properties.sv */
// Port assertions for the serial ROM command controller
`timescale 1ns/100ps
module secc_ctrl_properties #(
  parameter int TIMEOUT_CYC = 20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  // Engine
  input wire logic ROM_REQ,
  input wire logic [2:0] ROM_OP,
  input wire logic [7:0] ROM_ADDR,
  input wire logic ROM_DONE
);
  localparam int TLO = TIMEOUT_CYC - 4;
  logic pend_r, pend_nxt, ab_r, ab_nxt;
  int cnt_r, cnt_nxt, nd_r, nd_nxt;
  wire logic cmd = HSEL && HREADY && HTRANS[1] && HADDR[7:0] == 8'hB0;
  // Boot is followed from engine traffic only; a near timeout turns the boot checks off
  always_comb begin
    pend_nxt = ROM_REQ || (pend_r && !ROM_DONE);
    cnt_nxt = ROM_REQ ? 0 : cnt_r + 1;
    nd_nxt = nd_r + int'(ROM_DONE && nd_r < 6);
    ab_nxt = ab_r || (pend_r && cnt_r >= TLO);
  end
  always_ff @(posedge CLK) begin
    if (RST) {pend_r, ab_r, cnt_r, nd_r} <= '0;
    else {pend_r, ab_r, cnt_r, nd_r} <= {pend_nxt, ab_nxt, cnt_nxt, nd_nxt};
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_boot_start: assert property ($fell(RST) |-> ##[0:2] ROM_REQ)
    else $error("boot read not started");
  a_boot_busy: assert property (cmd && !HWRITE && nd_r < 6 && !ab_r && !ROM_DONE |=> HRDATA[31])
    else $error("busy clear during boot");
  a_boot_addr: assert property (ROM_REQ && nd_r < 6 && !ab_r |-> ROM_ADDR == 8'(nd_r) && ROM_OP == 3'h0)
    else $error("boot read out of order");
  a_cmd_start: assert property (cmd && HWRITE && !pend_r && nd_r == 6 ##1 HWDATA[31] && !ROM_DONE |=> ROM_REQ)
    else $error("command not started");
  a_cmd_hold: assert property (pend_r && cnt_r < TLO |-> $stable(ROM_OP) && $stable(ROM_ADDR))
    else $error("command changed while busy");
  a_one_cmd: assert property (ROM_REQ |-> !pend_r || cnt_r >= TIMEOUT_CYC - 2)
    else $error("command overlaps previous");
endmodule
bind secc_ctrl secc_ctrl_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (.CLK(CLK), .RST(RST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
  .ROM_REQ(ROM_REQ), .ROM_OP(ROM_OP), .ROM_ADDR(ROM_ADDR), .ROM_DONE(ROM_DONE));

/* secc_params.svh */
// Offsets, field positions, reset values and timing counts of the serial ROM command block
`ifndef SECC_PARAMS_SVH
`define SECC_PARAMS_SVH

`define SECC_CMD_OFS 8'hB0
`define SECC_DATA_OFS 8'hB4
`define SECC_ISTAT_OFS 8'hB8
`define SECC_IEN_OFS 8'hBC
`define SECC_ICLR_OFS 8'hC0

`define SECC_BUSY_BIT 31
`define SECC_OP_HI 30
`define SECC_OP_LO 28
`define SECC_ADDR_HI 7
`define SECC_ADDR_LO 0
`define SECC_DATA_HI 7
`define SECC_DATA_LO 0

`define SECC_IRQ_DONE_BIT 0
`define SECC_IRQ_TMO_BIT 1

`define SECC_OP_RST 3'h0
`define SECC_ADDR_RST 8'h00
`define SECC_DATA_RST 8'h00
`define SECC_IRQ_RST 2'h0
`define SECC_HWADDR_RST 48'h0000_0000_0000

`define SECC_BOOT_BASE 8'h00
`define SECC_BOOT_LAST 3'h5

`define SECC_CLK_PERIOD_NS 50
`define SECC_TIMEOUT_US 1000
`define SECC_TIMEOUT_CYC ((`SECC_TIMEOUT_US * 1000) / `SECC_CLK_PERIOD_NS)

`endif

/* secc_pkg.sv */
// Types shared by the serial ROM command block
package secc_pkg;
  typedef logic [2:0] secc_op_t;
  typedef enum logic [1:0] {
    BOOT_REQ,
    BOOT_WAIT,
    IDLE,
    RUN
  } secc_state_t;
endpackage

/* secc_rom_model.sv */
// Behavioural serial ROM engine facing the command controller
`timescale 1ns/100ps
module secc_rom_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command side
  input wire logic req,
  input wire logic [7:0] addr,
  output logic done,
  output logic [7:0] rdata,
  // Bench controls
  input wire logic absent,
  input wire logic [7:0] dly
);
  int cnt;
  logic [7:0] a;
  initial begin
    done = 0;
    rdata = 8'h00;
  end
  // Idle data is inverted every cycle so a stale byte never passes for a fresh one
  always @(posedge clk) begin
    done <= 0;
    rdata <= ~rdata;
    if (rst) cnt <= 0;
    else if (req) begin
      a <= addr;
      cnt <= absent ? 0 : dly; // No device fitted never answers
    end else if (cnt == 1) begin
      done <= 1;
      rdata <= a ^ 8'hC3;
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule

/* secc_timer.sv */
// Command timeout counter
`timescale 1ns/100ps
module secc_timer #(
  parameter int LIMIT = 20000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  secc_tmo_if.timer tmo
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (tmo.start) begin
      cnt_nxt = 32'h0000_0000;
    end else if (tmo.run && !tmo.expired) begin
      cnt_nxt = cnt_r + 32'h0000_0001;
    end
  end

  // Counts only while a command waits, so an absent device cannot stall the controller forever
  assign tmo.expired = tmo.run && !tmo.start && (cnt_r == 32'(LIMIT - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

/* secc_tmo_if.sv */
// Link between the command controller and its timeout counter
`timescale 1ns/100ps
interface secc_tmo_if;
  logic start;
  logic run;
  logic expired;
  modport ctrl (output start, output run, input expired);
  modport timer (input start, input run, output expired);
endinterface

/* serial_eeprom_command_ctrl_tb_top.sv */
// Self-checking bench for the serial ROM command controller
`timescale 1ns/100ps
module serial_eeprom_command_ctrl_tb_top;
  localparam int TMO = 20;
  logic CLK = 0, RST = 1, HSEL = 0, HWRITE = 0, absent = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, rd;
  logic [1:0] HTRANS = 0;
  logic [7:0] dly = 8'h03, q_adr, exp_q[$];
  logic [2:0] q_op;
  logic [47:0] hw;
  wire logic HREADY, HRESP, ROM_REQ, ROM_DONE, IRQ;
  wire logic [31:0] HRDATA;
  wire logic [2:0] ROM_OP;
  wire logic [7:0] ROM_ADDR, ROM_RDATA;
  wire logic [47:0] HW_ADDR;
  wire logic [7:0] wdat;
  int failures = 0, compares = 0, cyc = 0, n;
  secc_ctrl #(.TIMEOUT_CYC(TMO)) dut (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADY), .HRESP(HRESP),
    .HRDATA(HRDATA), .ROM_REQ(ROM_REQ), .ROM_OP(ROM_OP), .ROM_ADDR(ROM_ADDR), .ROM_WDATA(wdat), .ROM_DONE(ROM_DONE),
    .ROM_RDATA(ROM_RDATA), .HW_ADDR(HW_ADDR), .IRQ(IRQ));
  secc_rom_model rom (.clk(CLK), .rst(RST), .req(ROM_REQ), .addr(ROM_ADDR), .done(ROM_DONE), .rdata(ROM_RDATA),
    .absent(absent), .dly(dly));
  initial forever #25 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (ROM_REQ) begin
      q_op = ROM_OP;
      q_adr = ROM_ADDR;
    end
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  task chk(input string s, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1;
    HADDR <= {24'h00_0000, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    do @(posedge CLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask
  // Only reads while busy, so command and data stay untouched
  task idle(output int c);
    c = 0;
    do begin
      bus(0, 8'hB0, 0);
      c++;
    end while (rd[31] !== 1'b0 && c < 500);
  endtask
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    logic [7:0] a;
    void'($urandom(32'h7985));
    repeat (10) @(posedge CLK);
    RST <= 0;
    bus(0, 8'hB0, 0);
    chk("boot busy", rd[31], 1);
    chk("op reset", rd[30:28], 0);
    idle(n);
    for (int i = 0; i < 6; i++) hw[i*8 +: 8] = 8'(i) ^ 8'hC3;
    chk("hw addr", HW_ADDR, hw);
    bus(1, 8'hB4, 32'h0000_005A);
    bus(0, 8'hB4, 0);
    chk("data rw", rd[7:0], 8'h5A);
    chk("wdata", wdat, 8'h5A);
    chk("hresp", HRESP, 0);
    bus(1, 8'hBC, 3);
    bus(1, 8'hC0, 3);
    for (int op = 0; op < 8; op++) begin
      a = 8'($urandom);
      dly <= 8'($urandom_range(6, 1));
      if (op == 0) exp_q.push_back(a ^ 8'hC3);
      bus(1, 8'hB0, {1'b1, op[2:0], 20'h0_0000, a});
      bus(0, 8'hB0, 0);
      chk("busy", rd[31], 1);
      idle(n);
      chk("op", q_op, op[2:0]);
      chk("addr", q_adr, a);
      if (op == 0) begin
        bus(0, 8'hB4, 0);
        chk("data", rd[7:0], exp_q.pop_front());
      end
    end
    bus(0, 8'hB8, 0);
    chk("istat done", rd, 32'h0000_0001);
    chk("irq", IRQ, 1);
    bus(1, 8'hC0, 1);
    @(posedge CLK);
    chk("irq clr", IRQ, 0);
    absent <= 1;
    bus(1, 8'hB0, 32'h9000_0011);
    idle(n);
    chk("tmo len", n * 2 >= TMO && n * 2 <= TMO + 8, 1);
    bus(0, 8'hB8, 0);
    chk("istat tmo", rd, 32'h0000_0002);
    chk("irq tmo", IRQ, 1);
    bus(1, 8'hBC, 1);
    @(posedge CLK);
    chk("irq mask", IRQ, 0);
    bus(1, 8'h40, 32'hFFFF_FFFF);
    bus(0, 8'h40, 0);
    chk("unmapped", rd, 0);
    // Second reset with no device fitted: the address load must give up and leave the address cleared
    RST <= 1;
    repeat (2) @(posedge CLK);
    RST <= 0;
    bus(0, 8'hB0, 0);
    chk("reboot busy", rd[31], 1);
    idle(n);
    chk("boot tmo len", n * 2 >= TMO && n * 2 <= TMO + 8, 1);
    chk("hw addr clr", HW_ADDR, 0);
    end_sim();
  end
endmodule
